// ===== rtl/sadc_params.svh
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
`define SADC_CLK_PERIOD_NS 20
`define SADC_CONV_TIME_NS 3000
`define SADC_CONV_CYCLES ((`SADC_CONV_TIME_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_READ_GAP_NS 40
`define SADC_READ_GAP_CYCLES ((`SADC_READ_GAP_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_MODE_RESET 4'h0
`define SADC_MODE_PD_BIT 3
`define SADC_MODE_BANK_BIT 2
`define SADC_MODE_CNT_LSB 0
`define SADC_RES_WIDTH 14
`define SADC_MODE_WIDTH 4
`endif

// ===== rtl/sadc_pkg.sv
package sadc_pkg;
	typedef enum logic [1:0] {
		SADC_IDLE,
		SADC_CONV,
		SADC_DONE
	} sadc_state_type;

	typedef struct packed {
		logic pd;
		logic bank_b;
		logic [1:0] last_ch;
	} sadc_mode_type;

	typedef struct packed {
		logic [1:0] ch;
		logic [13:0] data;
	} sadc_word_type;
endpackage

// ===== rtl/sadc_buf2.sv
`timescale 1ns/1ps
// Two-entry skid buffer; stalling the drain side loses no word
module sadc_buf2 import sadc_pkg::*; #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [$clog2(DEPTH):0] cnt_q, cnt_d;
	logic [$clog2(DEPTH)-1:0] wp_q, wp_d, rp_q, rp_d;
	logic push, pop;

	always_comb begin
		push = in_valid_in && (cnt_q != DEPTH[$clog2(DEPTH):0]);
		pop = (cnt_q != '0) && out_ready_in;
		mem_d = mem_q;
		wp_d = wp_q;
		rp_d = rp_q;
		if (push) begin
			mem_d[wp_q] = in_data_in;
			wp_d = wp_q + 1'b1;
		end
		if (pop) begin
			rp_d = rp_q + 1'b1;
		end
		cnt_d = cnt_q + {{$clog2(DEPTH){1'b0}}, push} - {{$clog2(DEPTH){1'b0}}, pop};
		in_ready_out = (cnt_q != DEPTH[$clog2(DEPTH):0]);
		out_valid_out = (cnt_q != '0);
		out_data_out = mem_q[rp_q];
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			cnt_q <= '0;
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			cnt_q <= cnt_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
		mem_q <= mem_d;
	end
endmodule

// ===== rtl/sadc_seq.sv
`timescale 1ns/1ps
`include "sadc_params.svh"
// How it works
// - Strobe rising edge starts sequence, channel 0 first
// - Completion output falls after final channel
// - Result word is 14 bits, MSB highest
// - Low four lines: mode in, data out; here mode comes on its own 4-bit mode_code_bits_in
// - Each channel takes 3 us, stored
// - Starts ignored while sequence runs
// - After reset: bank A, one channel
// - Read rising edge advances pointer, wraps
module sadc_seq import sadc_pkg::*; #(
	parameter int CONV_CYCLES = `SADC_CONV_CYCLES,
	parameter int CHANNELS = 4
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic conversion_start_strobe_in,
	input wire logic cs_n_in,
	input wire logic wr_n_in,
	input wire logic rd_n_in,
	input wire logic [`SADC_MODE_WIDTH-1:0] mode_code_bits_in,
	output logic [`SADC_RES_WIDTH-1:0] result_bus_out,
	output logic result_bus_oe_n_out,
	output logic done_n_out,
	output logic powered_down_out,
	output logic bank_b_out,
	output logic [1:0] sample_ch_out,
	output logic sample_hold_out,
	input wire logic adc_valid_in,
	input wire logic [`SADC_RES_WIDTH-1:0] adc_data_in
);
	sadc_state_type st_q, st_d;
	sadc_mode_type mode_q, mode_d;
	logic [13:0] ram_q [CHANNELS];
	logic [13:0] ram_d [CHANNELS];
	logic [1:0] ch_q, ch_d, rptr_q, rptr_d;
	logic [$clog2(CONV_CYCLES+1)-1:0] tmr_q, tmr_d;
	logic cv_q, rd_q, wr_q, cs_q, done_n_q, done_n_d;
	logic [13:0] bus_d;
	logic oe_n_d;
	logic cv_rise, rd_rise, rd_fall, wr_rise, wr_rise_cs, seq_end;
	logic b_in_valid, b_in_ready, b_out_valid, b_out_ready;
	sadc_word_type b_in, b_out;

	function automatic logic [1:0] next_ch(input logic [1:0] c, input logic [1:0] last);
		next_ch = (c == last) ? 2'h0 : c + 2'h1;
	endfunction

	assign cv_rise = conversion_start_strobe_in && !cv_q;
	assign rd_fall = !rd_n_in && rd_q && !cs_n_in;
	assign rd_rise = rd_n_in && !rd_q && !cs_q;
	assign wr_rise = !wr_q && !cs_q && (wr_n_in || cs_n_in);
	assign wr_rise_cs = wr_rise && (st_q != SADC_CONV);
	assign seq_end = b_out_valid && (b_out.ch == mode_q.last_ch);

	// Each finished conversion waits here until the converter raises adc_valid_in
	always_comb begin
		b_in_valid = (st_q == SADC_CONV) && (tmr_q == '0) && adc_valid_in;
		b_in.ch = ch_q;
		b_in.data = adc_data_in;
		b_out_ready = 1'b1;
	end

	sadc_buf2 #(.WIDTH($bits(sadc_word_type)), .DEPTH(2)) u_buf (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.in_valid_in(b_in_valid),
		.in_ready_out(b_in_ready),
		.in_data_in(b_in),
		.out_valid_out(b_out_valid),
		.out_ready_in(b_out_ready),
		.out_data_out(b_out)
	);

	always_comb begin
		st_d = st_q;
		mode_d = mode_q;
		ch_d = ch_q;
		tmr_d = tmr_q;
		ram_d = ram_q;
		rptr_d = rptr_q;
		done_n_d = done_n_q;
		if (wr_rise_cs) begin
			mode_d = sadc_mode_type'(mode_code_bits_in);
		end
		if (b_out_valid) begin
			ram_d[b_out.ch] = b_out.data;
		end
		if (rd_fall) begin
			done_n_d = 1'b1;
		end
		if (rd_rise) begin
			rptr_d = next_ch(rptr_q, mode_q.last_ch);
		end
		unique case (st_q)
			SADC_IDLE, SADC_DONE: begin
				if (cv_rise && !mode_q.pd) begin
					st_d = SADC_CONV;
					ch_d = 2'h0;
					tmr_d = ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
					rptr_d = 2'h0;
				end
			end
			SADC_CONV: begin
				// Further strobes are not looked at here
				if (tmr_q != '0) begin
					tmr_d = tmr_q - 1'b1;
				end else if (b_in_valid && b_in_ready) begin
					if (ch_q == mode_q.last_ch) begin
						st_d = SADC_DONE;
					end else begin
						ch_d = ch_q + 2'h1;
						tmr_d = ($clog2(CONV_CYCLES+1))'(CONV_CYCLES - 1);
					end
				end
			end
			default: st_d = SADC_IDLE;
		endcase
		if (seq_end) begin
			done_n_d = 1'b0;
		end
		bus_d = ram_q[rptr_q];
		oe_n_d = !(!cs_n_in && !rd_n_in);
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st_q <= SADC_IDLE;
			mode_q <= sadc_mode_type'(`SADC_MODE_RESET);
			ch_q <= 2'h0;
			tmr_q <= '0;
			rptr_q <= 2'h0;
			done_n_q <= 1'b1;
			ram_q <= '{default: 14'h0};
			cv_q <= 1'b0;
			rd_q <= 1'b1;
			wr_q <= 1'b1;
			cs_q <= 1'b1;
		end else begin
			st_q <= st_d;
			mode_q <= mode_d;
			ch_q <= ch_d;
			tmr_q <= tmr_d;
			rptr_q <= rptr_d;
			done_n_q <= done_n_d;
			ram_q <= ram_d;
			cv_q <= conversion_start_strobe_in;
			rd_q <= rd_n_in || cs_n_in;
			wr_q <= wr_n_in || cs_n_in;
			cs_q <= cs_n_in;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			result_bus_out <= 14'h0;
			result_bus_oe_n_out <= 1'b1;
			done_n_out <= 1'b1;
			powered_down_out <= 1'b0;
			bank_b_out <= 1'b0;
			sample_ch_out <= 2'h0;
			sample_hold_out <= 1'b0;
		end else begin
			result_bus_out <= bus_d;
			result_bus_oe_n_out <= oe_n_d;
			done_n_out <= done_n_d;
			powered_down_out <= mode_d.pd;
			bank_b_out <= mode_d.bank_b;
			sample_ch_out <= ch_d;
			sample_hold_out <= (st_d == SADC_CONV);
		end
	end

	property p_start;
		@(posedge core_clk_in) disable iff (rst_in)
		(cv_rise && st_q != SADC_CONV && !mode_q.pd) |=> (st_q == SADC_CONV);
	endproperty
	a_start: assert property (p_start) else $error("start edge did not begin sequence");

	property p_ignore;
		@(posedge core_clk_in) disable iff (rst_in)
		(st_q == SADC_CONV && tmr_q != '0) |=> (st_q == SADC_CONV && $stable(ch_q));
	endproperty
	a_ignore: assert property (p_ignore) else $error("sequence disturbed mid conversion");

	property p_done;
		@(posedge core_clk_in) disable iff (rst_in)
		$rose(st_q == SADC_DONE) |-> ##[1:3] !done_n_out;
	endproperty
	a_done: assert property (p_done) else $error("completion not flagged");

	property p_conv_time;
		@(posedge core_clk_in) disable iff (rst_in)
		(cv_rise && st_q != SADC_CONV && !mode_q.pd) |=> (tmr_q == CONV_CYCLES - 1);
	endproperty
	a_conv_time: assert property (p_conv_time) else $error("per-channel time wrong");

	property p_reset_mode;
		@(posedge core_clk_in) $fell(rst_in) |-> (mode_q == `SADC_MODE_RESET);
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("reset mode wrong");

	property p_ptr;
		@(posedge core_clk_in) disable iff (rst_in)
		(rd_rise && rptr_q == mode_q.last_ch && !(cv_rise && st_q != SADC_CONV))
			|=> (rptr_q == 2'h0);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer did not wrap");

	// A stored word reaches the lines two edges later while the pointer rests on it
	property p_bus;
		@(posedge core_clk_in) disable iff (rst_in)
		(b_out_valid && b_out.ch == rptr_q && !rd_rise && !(cv_rise && st_q != SADC_CONV))
			|=> ##1 (result_bus_out == $past(b_out.data, 2));
	endproperty
	a_bus: assert property (p_bus) else $error("result word not presented");

	property p_mode_wr;
		@(posedge core_clk_in) disable iff (rst_in)
		wr_rise_cs |=> (mode_q == $past(mode_code_bits_in));
	endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode code not latched");

	c_seq: cover property (@(posedge core_clk_in) disable iff (rst_in) $fell(done_n_out));
	c_four: cover property (@(posedge core_clk_in) disable iff (rst_in)
		st_q == SADC_CONV && ch_q == 2'h3);
	c_wrap: cover property (@(posedge core_clk_in) disable iff (rst_in)
		rd_rise && rptr_q == mode_q.last_ch);
	c_stall: cover property (@(posedge core_clk_in) disable iff (rst_in)
		st_q == SADC_CONV && tmr_q == '0 && !adc_valid_in);
endmodule

// ===== verification/sadc_host_model.sv
`timescale 1ns/1ps
// Host bus side: mode writes, start strobes and result reads
module sadc_host_model (
	input wire logic clk_in,
	input wire logic [13:0] data_in,
	input wire logic oe_n_in,
	output logic strobe_out,
	output logic cs_n_out,
	output logic wr_n_out,
	output logic rd_n_out,
	output logic [3:0] mode_out
);
	initial begin
		strobe_out = 1'b0;
		cs_n_out = 1'b1;
		wr_n_out = 1'b1;
		rd_n_out = 1'b1;
		mode_out = 4'hf;
	end
	task automatic write_mode(input logic [3:0] code);
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		wr_n_out <= 1'b0;
		mode_out <= code;
		repeat (2) @(posedge clk_in);
		wr_n_out <= 1'b1;
		cs_n_out <= 1'b1;
		@(posedge clk_in);
		mode_out <= ~code; // Released lines stop showing the code
	endtask
	task automatic start();
		@(posedge clk_in);
		strobe_out <= 1'b1;
		repeat (2) @(posedge clk_in);
		strobe_out <= 1'b0;
	endtask
	task automatic read_word(output logic [14:0] w);
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		rd_n_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		w = {oe_n_in, data_in};
		rd_n_out <= 1'b1;
		cs_n_out <= 1'b1;
		repeat (2) @(posedge clk_in);
	endtask
endmodule

// ===== verification/sadc_seq_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module sadc_seq_tb;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic strobe, cs_n, wr_n, rd_n, oe_n, done_n, pd, bank_b, hold;
	logic [3:0] mode;
	logic [13:0] res;
	logic [1:0] ch;
	int comparisons = 0;
	int n_mismatch = 0;
	int hold_cnt = 0;
	localparam int CONV = 4;
	logic adc_valid = 1'b1;
	sadc_seq #(.CONV_CYCLES(CONV), .CHANNELS(4)) dut (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .conversion_start_strobe_in(strobe),
		.cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n), .mode_code_bits_in(mode),
		.result_bus_out(res), .result_bus_oe_n_out(oe_n), .done_n_out(done_n),
		.powered_down_out(pd), .bank_b_out(bank_b), .sample_ch_out(ch),
		.sample_hold_out(hold), .adc_valid_in(adc_valid), .adc_data_in({bank_b, 11'h155, ch})
	);
	sadc_host_model host (
		.clk_in(core_clk_in), .data_in(res), .oe_n_in(oe_n), .strobe_out(strobe),
		.cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n), .mode_out(mode)
	);
	initial begin
		forever #10 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		if (hold === 1'b1) hold_cnt++;
	end
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic run_mode(input logic [3:0] code, input bit wr, input int stall);
		int i, n;
		logic [14:0] w;
		if (wr) host.write_mode(code);
		#1;
		`CHK("bank_b", code[2], bank_b)
		`CHK("pd", 1'b0, pd)
		hold_cnt = 0;
		if (stall > 0) begin
			@(posedge core_clk_in);
			adc_valid <= 1'b0;
		end
		host.start();
		host.start(); // Lands mid-sequence and must be ignored
		if (stall > 0) begin
			repeat (stall) @(posedge core_clk_in);
			adc_valid <= 1'b1;
		end
		for (i = 0; i < 200 && done_n !== 1'b0; i++) @(posedge core_clk_in);
		#1;
		`CHK("done_n", 1'b0, done_n)
		n = code[1:0] + 1;
		`CHK("hold", CONV * n + ((stall > 0) ? stall + 1 : 0), hold_cnt)
		for (i = 0; i <= n; i++) begin
			host.read_word(w);
			`CHK("oe_n", 1'b0, w[14])
			`CHK("word", {code[2], 11'h155, 2'(i % n)}, w[13:0])
		end
		`CHK("done_n", 1'b1, done_n)
		`CHK("oe_n idle", 1'b1, oe_n)
		$display("mode %h test done", code);
	endtask
	task automatic t_reset();
		host.start();
		repeat (3) @(posedge core_clk_in);
		rst_in <= 1'b1;
		repeat (3) @(posedge core_clk_in);
		rst_in <= 1'b0;
		#1;
		`CHK("hold", 1'b0, hold)
		`CHK("done_n", 1'b1, done_n)
		run_mode(4'h0, 1'b0, 0);
		$display("reset test done");
	endtask
	task automatic t_power_down();
		host.write_mode(4'h8);
		#1;
		`CHK("pd", 1'b1, pd)
		host.start();
		repeat (30) @(posedge core_clk_in);
		#1;
		`CHK("done_n", 1'b1, done_n)
		$display("power down test done");
	endtask
	initial begin
		repeat (30000) @(posedge core_clk_in);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge core_clk_in);
		rst_in <= 1'b0;
		#1;
		`CHK("done_n", 1'b1, done_n)
		`CHK("oe_n", 1'b1, oe_n)
		run_mode(4'h0, 1'b0, 0);
		for (int m = 0; m < 8; m++) run_mode(4'(m), 1'b1, 0);
		run_mode(4'h7, 1'b1, 5); // Converter holds its result back
		t_reset();
		t_power_down();
		wrap_up();
	end
endmodule
